// ===== rtl/usb_device_endpoint_irq_masks.sv
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "ep_irq_regs.svh"


module usb_device_endpoint_irq_masks
    import ep_irq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] ep_cond,
    output logic             ctrl_irq,
    output logic             irq,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take  = s_axi_wvalid && s_axi_wready;
    wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;

    function automatic logic addr_known(input logic [11:0] a);
        return a == `OFF_MASK_LOW || a == `OFF_MASK_HIGH || a == `OFF_STATUS_LOW ||
               a == `OFF_STATUS_HIGH || a == `OFF_IRQ_STATUS || a == `OFF_IRQ_ENABLE;
    endfunction

    // Reserved upper bits of every register read as zero
    function automatic logic [31:0] pad_byte(input ep_vec_t v);
        return {24'h000000, v};
    endfunction

    function automatic logic [31:0] pad_pair(input logic [1:0] v);
        return {30'h0, v};
    endfunction

    // Write-one-to-clear: only a decoded write clears anything
    function automatic ep_vec_t w1c_mask(input logic hit, input ep_vec_t d);
        return hit ? d : 8'h00;
    endfunction

    // Only the low byte carries state, so byte lane 0 decides a write
    wire logic lane0    = w_strb[0];
    wire logic wr_mlow  = wr_fire && lane0 && aw_addr == `OFF_MASK_LOW;
    wire logic wr_mhigh = wr_fire && lane0 && aw_addr == `OFF_MASK_HIGH;
    wire logic wr_slow  = wr_fire && lane0 && aw_addr == `OFF_STATUS_LOW;
    wire logic wr_shigh = wr_fire && lane0 && aw_addr == `OFF_STATUS_HIGH;
    wire logic wr_ists  = wr_fire && lane0 && aw_addr == `OFF_IRQ_STATUS;
    wire logic wr_ien   = wr_fire && lane0 && aw_addr == `OFF_IRQ_ENABLE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_addr       <= 12'h000;
            s_axi_awready <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            // Readies wait for the answer to go, so a slow bready stalls the master
            s_axi_awready <= !aw_held && !aw_take && !s_axi_awready && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            // Same hold-off as the address channel
            s_axi_wready <= !w_held && !w_take && !s_axi_wready && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Mask registers
    // ----------------------------------------
    ep_vec_t mask_low;
    ep_vec_t mask_high;

    ep_mask_reg #(
        .WIDTH   (`EP_FIELD_W)
    ) u_mask_low (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_mlow),
        .wr_data (w_data[7:0]),
        .mask    (mask_low)
    );

    ep_mask_reg #(
        .WIDTH   (`EP_FIELD_W)
    ) u_mask_high (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_mhigh),
        .wr_data (w_data[7:0]),
        .mask    (mask_high)
    );

    // ----------------------------------------
    // Endpoint status
    // ----------------------------------------
    ep_vec_t status_low;
    ep_vec_t status_high;
    logic    any_low;
    logic    any_high;
    logic    new_low;
    logic    new_high;

    wire ep_vec_t clr_low  = w1c_mask(wr_slow, w_data[7:0]);
    wire ep_vec_t clr_high = w1c_mask(wr_shigh, w_data[7:0]);

    ep_status_bank #(
        .WIDTH   (`EP_FIELD_W)
    ) u_status_low (
        .aclk    (aclk),
        .aresetn (aresetn),
        .mask    (mask_low),
        .cond    (ep_cond[7:0]),
        .clear   (clr_low),
        .status  (status_low),
        .any_set (any_low),
        .new_set (new_low)
    );

    ep_status_bank #(
        .WIDTH   (`EP_FIELD_W)
    ) u_status_high (
        .aclk    (aclk),
        .aresetn (aresetn),
        .mask    (mask_high),
        .cond    (ep_cond[15:8]),
        .clear   (clr_high),
        .status  (status_high),
        .any_set (any_high),
        .new_set (new_high)
    );

    // ----------------------------------------
    // Interrupt outputs
    // ----------------------------------------
    logic [1:0] irq_status;
    logic [1:0] irq_enable;

    wire logic [1:0] irq_ev   = {new_high, new_low};
    wire logic [1:0] irq_clr  = wr_ists ? w_data[1:0] : 2'h0;
    wire logic [1:0] next_irq = irq_ev | (irq_status & ~irq_clr);

    // Event bits: a new rise wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= next_irq;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable <= `IRQ_ENABLE_RESET;
        end else if (wr_ien) begin
            irq_enable <= w_data[1:0];
        end
    end

    // New enable is used at once, so the output never lags the write
    wire logic [1:0] next_enable = wr_ien ? w_data[1:0] : irq_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_irq <= 1'b0;
            irq      <= 1'b0;
        end else begin
            ctrl_irq <= any_low || any_high;
            irq      <= |(next_irq & next_enable);
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    wire logic rd_mlow  = s_axi_araddr == `OFF_MASK_LOW;
    wire logic rd_mhigh = s_axi_araddr == `OFF_MASK_HIGH;
    wire logic rd_slow  = s_axi_araddr == `OFF_STATUS_LOW;
    wire logic rd_shigh = s_axi_araddr == `OFF_STATUS_HIGH;
    wire logic rd_ists  = s_axi_araddr == `OFF_IRQ_STATUS;
    wire logic rd_ien   = s_axi_araddr == `OFF_IRQ_ENABLE;

    // upper bits zero
    // Unmapped addresses read as zero and answer with an error
    wire logic [31:0] rd_word =
        rd_mlow  ? pad_byte(mask_low)    :
        rd_mhigh ? pad_byte(mask_high)   :
        rd_slow  ? pad_byte(status_low)  :
        rd_shigh ? pad_byte(status_high) :
        rd_ists  ? pad_pair(irq_status)  :
        rd_ien   ? pad_pair(irq_enable)  : 32'h0000_0000;

    wire logic ar_take = s_axi_arvalid && s_axi_arready;

    // One read at a time: no new address while data waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // usb_device_endpoint_irq_masks

// ===== rtl/ep_irq_regs.svh
`ifndef EP_IRQ_REGS_SVH
`define EP_IRQ_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFF_MASK_LOW     12'h050
`define OFF_MASK_HIGH    12'h054
`define OFF_STATUS_LOW   12'h058
`define OFF_STATUS_HIGH  12'h05c
`define OFF_IRQ_STATUS   12'h060
`define OFF_IRQ_ENABLE   12'h064

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define EP_FIELD_W       8
`define MASK_RESET       8'hff
`define STATUS_RESET     8'h00
`define IRQ_EV_W         2
`define IRQ_EV_LOW       0
`define IRQ_EV_HIGH      1
`define IRQ_ENABLE_RESET 2'h0

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== rtl/ep_irq_pkg.sv
package ep_irq_pkg;
    typedef logic [7:0] ep_vec_t;
    typedef enum logic [1:0] {
        bus_idle,
        bus_resp
    } bus_state_t;
    typedef logic [1:0] axi_resp_t;
endpackage

// ===== rtl/ep_status_bank.sv
`timescale 1ns/100ps
`include "ep_irq_regs.svh"

module ep_status_bank
    import ep_irq_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic [WIDTH-1:0] clear,
    output logic      [WIDTH-1:0] status,
    output logic                  any_set,
    output logic                  new_set
);
    initial begin
        if (WIDTH < 1 || WIDTH > 32) begin
            $error("ep_status_bank WIDTH out of range");
        end
    end

    wire logic [WIDTH-1:0] set_ok = cond & ~mask;
    // Set wins over a clear in the same cycle; masking never clears
    wire logic [WIDTH-1:0] next_status = set_ok | (status & ~clear);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status  <= '0;
            any_set <= 1'b0;
            new_set <= 1'b0;
        end else begin
            status  <= next_status;
            any_set <= |next_status;
            new_set <= |(set_ok & ~status);
        end
    end
endmodule // ep_status_bank

// ===== rtl/ep_mask_reg.sv
`timescale 1ns/100ps
`include "ep_irq_regs.svh"

module ep_mask_reg
    import ep_irq_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] mask
);
    initial begin
        if (WIDTH != `EP_FIELD_W) begin
            $error("ep_mask_reg WIDTH must match the endpoint field");
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask <= `MASK_RESET;
        end else if (wr_en) begin
            mask <= wr_data;
        end
    end
endmodule // ep_mask_reg

// ===== tb/usb_device_endpoint_irq_masks_monitor.sv
`timescale 1ns/100ps
module usb_device_endpoint_irq_masks_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [15:0] ep_cond,
    input wire logic        ctrl_irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rise;
        $rose(ctrl_irq) |-> $past(ep_cond, 2) != 16'h0;
    endproperty
    a_rise: assert property (p_rise) else $error("request rose with no cause");
    property p_fall;
        $fell(ctrl_irq) |-> $past(s_axi_bvalid);
    endproperty
    a_fall: assert property (p_fall) else $error("request dropped without a clear");
    property p_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("reserved bits not zero");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_blat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer not held");
    property p_bexcl;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bexcl: assert property (p_bexcl) else $error("write taken while answering");
endmodule // usb_device_endpoint_irq_masks_monitor

bind usb_device_endpoint_irq_masks usb_device_endpoint_irq_masks_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .ep_cond(ep_cond), .ctrl_irq(ctrl_irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ===== tb/usb_device_endpoint_irq_masks_test.sv
`timescale 1ns/100ps
`include "ep_irq_regs.svh"
module usb_device_endpoint_irq_masks_test;
    logic        aclk = 1'b0, aresetn = 1'b0, ctrl_irq, irq;
    logic [15:0] ep_cond = 16'h0, m;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          errors = 0, num_checks = 0;

    usb_device_endpoint_irq_masks dut (.*);

    always #2 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Status bit shows one edge later, the request one more
    task automatic pulse(input logic [15:0] c);
        @(posedge aclk);
        ep_cond <= c;
        @(posedge aclk);
        ep_cond <= 16'h0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h4c03670b));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFF_MASK_LOW, 32'hff, `RESP_OKAY);
        rd(`OFF_MASK_HIGH, 32'hff, `RESP_OKAY);
        repeat (20) begin
            @(posedge aclk);
            ep_cond <= 16'($urandom);
        end
        pulse(16'h0);
        chk({31'h0, ctrl_irq}, 32'h0);
        rd(`OFF_STATUS_LOW, 32'h0, `RESP_OKAY);
        rd(`OFF_STATUS_HIGH, 32'h0, `RESP_OKAY);
        v = $urandom;
        wr(`OFF_MASK_HIGH, v, 4'hf, `RESP_OKAY);
        rd(`OFF_MASK_HIGH, {24'h0, v[7:0]}, `RESP_OKAY);
        // Lane 0 off, so the write must be dropped
        wr(`OFF_MASK_LOW, v, 4'he, `RESP_OKAY);
        rd(`OFF_MASK_LOW, 32'hff, `RESP_OKAY);
        wr(12'h100, v, 4'hf, `RESP_SLVERR);
        rd(12'h100, 32'h0, `RESP_SLVERR);
        wr(`OFF_IRQ_ENABLE, 32'h3, 4'hf, `RESP_OKAY);
        for (int n = 0; n < 16; n++) begin
            m = ~(16'h1 << n);
            wr(`OFF_MASK_LOW, {24'h0, m[7:0]}, 4'hf, `RESP_OKAY);
            wr(`OFF_MASK_HIGH, {24'h0, m[15:8]}, 4'hf, `RESP_OKAY);
            pulse(16'hffff);
            chk({31'h0, ctrl_irq}, 32'h1);
            chk({31'h0, irq}, 32'h1);
            wr(`OFF_MASK_LOW, 32'hff, 4'hf, `RESP_OKAY);
            wr(`OFF_MASK_HIGH, 32'hff, 4'hf, `RESP_OKAY);
            wr(n < 8 ? `OFF_STATUS_LOW : `OFF_STATUS_HIGH, 32'h0, 4'hf, `RESP_OKAY);
            rd(`OFF_STATUS_LOW, {24'h0, ~m[7:0]}, `RESP_OKAY);
            rd(`OFF_STATUS_HIGH, {24'h0, ~m[15:8]}, `RESP_OKAY);
            wr(n < 8 ? `OFF_STATUS_LOW : `OFF_STATUS_HIGH, 32'hff, 4'hf, `RESP_OKAY);
            wr(`OFF_IRQ_STATUS, 32'h3, 4'hf, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk({31'h0, ctrl_irq}, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Enable gates only the output, not the event bit
        wr(`OFF_IRQ_ENABLE, 32'h0, 4'hf, `RESP_OKAY);
        wr(`OFF_MASK_LOW, 32'hfe, 4'hf, `RESP_OKAY);
        pulse(16'h0001);
        chk({31'h0, irq}, 32'h0);
        rd(`OFF_IRQ_STATUS, 32'h1, `RESP_OKAY);
        wr(`OFF_IRQ_ENABLE, 32'h1, 4'hf, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFF_IRQ_STATUS, 32'h1, 4'hf, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        close_out;
    end

    // Whole run needs about a thousand cycles
    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        close_out;
    end
endmodule // usb_device_endpoint_irq_masks_test
